//--- hdl/rtsl_consts.vh
// Behaviour
// - Time-out counting starts only at first rising edge of master_clear_n.
// - Power-up holds reset for longer of 96 ms or 1024 oscillator periods.
// - Oscillator start-up timer runs in every mode at power-on, else only in crystal modes; sleep wake waits 1024.
// - Start-up timer used for power-on, sleep resets and wake; not running resets.
// - Every reset source loads program counter with 0000h.
// - Power-on, running master-clear, or clear-watchdog set both flags to 1.
// - Master-clear in sleep or interrupt wake: timeout 1, powerdown 0.
// - Watchdog reset while running: timeout 0, powerdown 1.
// - Watchdog reset during sleep clears both flags.
// - Watchdog reset during sleep branches to reset vector zero.
// - Every reset sets stack-available and global-interrupt-disable to 1.
// - Interrupt wake loads PC+1; stack-available set to 1, global-interrupt-disable taken from interrupt-disable state.
// - Interrupt wake runs next instruction, then vectors if interrupts enabled.
// - Start-up timer counts 1024 valid oscillator pulses after master-clear high or wake.
// - Power-on with master-clear high starts both timers together.
`ifndef RTSL_CONSTS_VH
`define RTSL_CONSTS_VH
`define RTSL_CLK_HZ 20000000
`define RTSL_PWRUP_MS 96
`define RTSL_PWRUP_CYC ((`RTSL_CLK_HZ / 1000) * `RTSL_PWRUP_MS)
`define RTSL_OSC_WAIT_PULSES 1024
`define RTSL_RESET_VECTOR 16'h0000
`define RTSL_PC_INC 16'h0001
`define RTSL_MODE_LOWXTAL 2'h0
`define RTSL_MODE_XTAL 2'h1
`define RTSL_MODE_EXTCLK 2'h2
`define RTSL_MODE_RESCAP 2'h3
`define RTSL_IRQ_BIT 0
`define RTSL_ADDR_STAT 4'h0
`define RTSL_ADDR_MASK 4'h1
`define RTSL_ADDR_CAUSE 4'h2
`define RTSL_ADDR_MODE 4'h3
`define RTSL_EVT_W 4
`define RTSL_CAUSE_POWERON 4'h1
`define RTSL_CAUSE_PIN 4'h2
`define RTSL_CAUSE_SLEEP 4'h4
`define RTSL_CAUSE_WDT 4'h8
`endif

//--- hdl/rtsl_counter.v
`timescale 1ns/1ps
`default_nettype none
module rtsl_counter #(
    parameter WIDTH = 24
) (
    input wire sys_clk,
    input wire clear,
    input wire start,
    input wire tick,
    input wire [WIDTH-1:0] target,
    output reg running,
    output reg done
);
reg [WIDTH-1:0] count_r;
always @(posedge sys_clk) begin
    if (clear) begin
        count_r <= {WIDTH{1'b0}};
        running <= 1'b0;
        done <= 1'b0;
    end else if (start) begin
        count_r <= {WIDTH{1'b0}};
        running <= 1'b1;
        done <= 1'b0;
    end else if (running && tick) begin
        if (count_r == target - {{(WIDTH-1){1'b0}}, 1'b1}) begin
            running <= 1'b0;
            done <= 1'b1;
        end
        count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
end
endmodule
`default_nettype wire

//--- hdl/rtsl_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "rtsl_consts.vh"
module rtsl_sequencer #(
    parameter PWRUP_CYCLES = `RTSL_PWRUP_CYC,
    parameter OSC_WAIT_COUNT = `RTSL_OSC_WAIT_PULSES,
    parameter CNT_W = 24
) (
    input wire sys_clk,
    input wire rst,
    input wire master_clear_n,
    input wire osc_pulse,
    input wire osc_valid,
    input wire [1:0] osc_mode,
    input wire sleeping,
    input wire wdt_timeout,
    input wire wake_irq,
    input wire clear_watchdog_instr,
    input wire [15:0] pc_current,
    input wire global_int_disable_in,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg core_reset,
    output reg pc_load,
    output reg [15:0] pc_value,
    output reg int_vector_req,
    output reg timeout_flag,
    output reg powerdown_flag,
    output reg global_int_disable,
    output reg stack_available_flag,
    output reg irq
);
////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 4'b0001;
localparam ST_WAIT_MC = 4'b0010;
localparam ST_TIMING = 4'b0100;
localparam ST_RUN = 4'b1000;
reg [3:0] state_r;
reg [3:0] state_nxt;
reg mcPrev_r;
reg wakeKind_r;
reg useOsc_r;
reg usePwr_r;
reg [`RTSL_EVT_W-1:0] stat_r;
reg [`RTSL_EVT_W-1:0] mask_r;
reg [`RTSL_EVT_W-1:0] cause_r;
reg oscStart;
reg pwrStart;
wire oscRun;
wire oscDone;
wire pwrRun;
wire pwrDone;
wire crystal = (osc_mode == `RTSL_MODE_XTAL) || (osc_mode == `RTSL_MODE_LOWXTAL);
wire mcRise = master_clear_n && !mcPrev_r;
wire mcLow = !master_clear_n;
wire wdtReset = wdt_timeout && state_r == ST_RUN;
wire wakeEvt = wake_irq && sleeping && state_r == ST_RUN && !wdtReset && !mcLow;
wire timersDone = (!useOsc_r || oscDone) && (!usePwr_r || pwrDone);
////////////////////////////////////////////////////////////////////////
// Oscillator pulses only counted once input amplitude is valid
rtsl_counter #(.WIDTH(CNT_W)) oscCnt (
    .sys_clk(sys_clk),
    .clear(rst || mcLow),
    .start(oscStart),
    .tick(osc_pulse && osc_valid),
    .target(OSC_WAIT_COUNT[CNT_W-1:0]),
    .running(oscRun),
    .done(oscDone)
);
rtsl_counter #(.WIDTH(CNT_W)) pwrCnt (
    .sys_clk(sys_clk),
    .clear(rst || mcLow),
    .start(pwrStart),
    .tick(1'b1),
    .target(PWRUP_CYCLES[CNT_W-1:0]),
    .running(pwrRun),
    .done(pwrDone)
);
////////////////////////////////////////////////////////////////////////
always @* begin
    state_nxt = state_r;
    oscStart = 1'b0;
    pwrStart = 1'b0;
    case (state_r)
        ST_IDLE: begin
            if (mcRise) begin
                state_nxt = ST_TIMING;
                oscStart = 1'b1;
                pwrStart = 1'b1;
            end else if (!mcLow) begin
                state_nxt = ST_WAIT_MC;
            end
        end
        ST_WAIT_MC: begin
            if (mcRise) begin
                state_nxt = ST_TIMING;
                oscStart = useOsc_r && crystal;
            end
        end
        ST_TIMING: begin
            if (mcLow) begin
                state_nxt = ST_WAIT_MC;
            end else if (timersDone && !oscRun && !pwrRun) begin
                state_nxt = ST_RUN;
            end
        end
        ST_RUN: begin
            if (mcLow) begin
                state_nxt = ST_WAIT_MC;
            end else if (wdtReset || wakeEvt) begin
                state_nxt = ST_TIMING;
                oscStart = sleeping && crystal;
            end
        end
        default: state_nxt = ST_IDLE;
    endcase
end
////////////////////////////////////////////////////////////////////////
always @(posedge sys_clk) begin
    if (rst) begin
        state_r <= ST_IDLE;
        // Low so a pin already high at power-on counts as the first rise
        mcPrev_r <= 1'b0;
        wakeKind_r <= 1'b0;
        useOsc_r <= 1'b1;
        usePwr_r <= 1'b1;
        core_reset <= 1'b1;
        pc_load <= 1'b0;
        pc_value <= `RTSL_RESET_VECTOR;
        int_vector_req <= 1'b0;
        timeout_flag <= 1'b1;
        powerdown_flag <= 1'b1;
        global_int_disable <= 1'b1;
        stack_available_flag <= 1'b1;
        cause_r <= `RTSL_CAUSE_POWERON;
    end else begin
        state_r <= state_nxt;
        mcPrev_r <= master_clear_n;
        pc_load <= 1'b0;
        int_vector_req <= 1'b0;
        if (state_r == ST_TIMING && state_nxt == ST_RUN) begin
            core_reset <= 1'b0;
            pc_load <= 1'b1;
            // Vector only after the instruction following sleep runs
            int_vector_req <= wakeKind_r && !global_int_disable;
        end
        if (state_r == ST_IDLE && state_nxt == ST_TIMING) begin
            useOsc_r <= crystal;
            usePwr_r <= 1'b1;
        end
        if (mcLow && state_r != ST_IDLE && state_r != ST_WAIT_MC) begin
            core_reset <= 1'b1;
            wakeKind_r <= 1'b0;
            usePwr_r <= 1'b0;
            useOsc_r <= sleeping;
            pc_value <= `RTSL_RESET_VECTOR;
            timeout_flag <= 1'b1;
            powerdown_flag <= !sleeping;
            global_int_disable <= 1'b1;
            stack_available_flag <= 1'b1;
            cause_r <= sleeping ? `RTSL_CAUSE_SLEEP : `RTSL_CAUSE_PIN;
        end else if (wdtReset) begin
            core_reset <= 1'b1;
            wakeKind_r <= 1'b0;
            usePwr_r <= 1'b0;
            useOsc_r <= sleeping && crystal;
            pc_value <= `RTSL_RESET_VECTOR;
            timeout_flag <= 1'b0;
            powerdown_flag <= !sleeping;
            global_int_disable <= 1'b1;
            stack_available_flag <= 1'b1;
            cause_r <= `RTSL_CAUSE_WDT;
        end else if (wakeEvt) begin
            // Core held only while the wake start-up delay runs
            core_reset <= 1'b1;
            wakeKind_r <= 1'b1;
            usePwr_r <= 1'b0;
            useOsc_r <= crystal;
            pc_value <= pc_current + `RTSL_PC_INC;
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b0;
            global_int_disable <= global_int_disable_in;
            stack_available_flag <= 1'b1;
            cause_r <= `RTSL_CAUSE_SLEEP;
        end else if (clear_watchdog_instr && state_r == ST_RUN) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
        end else if (state_r == ST_RUN) begin
            global_int_disable <= global_int_disable_in;
        end
    end
end
////////////////////////////////////////////////////////////////////////
// Sticky event bits, set beats software clear
wire [`RTSL_EVT_W-1:0] evtSet = {wdtReset, wakeEvt, mcLow && mcPrev_r,
    state_r == ST_TIMING && state_nxt == ST_RUN};
wire [`RTSL_EVT_W-1:0] clrBits = (reg_wr && reg_addr == `RTSL_ADDR_STAT) ?
    reg_wdata[`RTSL_EVT_W-1:0] : {`RTSL_EVT_W{1'b0}};
always @(posedge sys_clk) begin
    if (rst) begin
        stat_r <= {`RTSL_EVT_W{1'b0}};
        mask_r <= {`RTSL_EVT_W{1'b0}};
        reg_rdata <= 8'h00;
        irq <= 1'b0;
    end else begin
        stat_r <= (stat_r & ~clrBits) | evtSet;
        if (reg_wr && reg_addr == `RTSL_ADDR_MASK) begin
            mask_r <= reg_wdata[`RTSL_EVT_W-1:0];
        end
        irq <= |(stat_r & mask_r);
        reg_rdata <= 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `RTSL_ADDR_STAT: reg_rdata <= {4'h0, stat_r};
                `RTSL_ADDR_MASK: reg_rdata <= {4'h0, mask_r};
                `RTSL_ADDR_CAUSE: reg_rdata <= {4'h0, cause_r};
                `RTSL_ADDR_MODE: reg_rdata <= {2'h0, stack_available_flag, global_int_disable,
                    timeout_flag, powerdown_flag, osc_mode};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
end
endmodule
`default_nettype wire

//--- test/rtsl_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module rtsl_osc_model (
    input wire logic sys_clk,
    input wire logic pinLow,
    output logic master_clear_n,
    output logic osc_pulse,
    output logic osc_valid
);
    logic [7:0] cnt_r = 8'h00;
    logic warm_r = 1'b0;
    assign master_clear_n = !pinLow;
    always @(posedge sys_clk) begin
        cnt_r <= cnt_r + 8'h01;
        if (cnt_r == 8'h05) begin
            warm_r <= 1'b1;
        end
    end
    // No pulses before amplitude settles, so early edges must not count
    assign osc_valid = warm_r;
    assign osc_pulse = warm_r && cnt_r[0];
endmodule
`default_nettype wire

//--- test/rtsl_seq_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rtsl_seq_sva (
    input wire sys_clk,
    input wire rst,
    input wire master_clear_n,
    input wire sleeping,
    input wire wdt_timeout,
    input wire clear_watchdog_instr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire core_reset,
    input wire pc_load,
    input wire [15:0] pc_value,
    input wire int_vector_req,
    input wire timeout_flag,
    input wire powerdown_flag,
    input wire global_int_disable,
    input wire stack_available_flag
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    a_pin_holds_core: assert property (!master_clear_n ##1 !master_clear_n |-> core_reset)
        else $error("core not held while pin low");
    a_release_loads_pc: assert property ($fell(core_reset) |-> pc_load)
        else $error("release without pc load");
    a_pc_load_single: assert property (pc_load |=> !pc_load)
        else $error("pc load longer than one cycle");
    a_vector_at_release: assert property (int_vector_req |-> pc_load && !global_int_disable)
        else $error("vector request outside wake release");
    a_reset_stack_bit: assert property ($rose(core_reset) && pc_value == 16'h0000 |->
        stack_available_flag && global_int_disable)
        else $error("reset did not set upper status pair");
    a_wdt_run_flags: assert property (wdt_timeout && !sleeping && !core_reset |-> ##[1:2]
        !timeout_flag && powerdown_flag)
        else $error("running watchdog flags wrong");
    a_wdt_sleep_flags: assert property (wdt_timeout && sleeping && !core_reset |-> ##[1:2]
        !timeout_flag && !powerdown_flag)
        else $error("sleeping watchdog flags wrong");
    a_clear_watchdog_instr_flags: assert property (clear_watchdog_instr && !core_reset |-> ##[1:2]
        timeout_flag && powerdown_flag)
        else $error("clear watchdog flags wrong");
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    c_release: cover property ($fell(core_reset));
    c_vector: cover property (int_vector_req);
    c_wdt_sleep: cover property (wdt_timeout && sleeping);
endmodule
bind rtsl_sequencer rtsl_seq_sva u_rtsl_seq_sva (.sys_clk, .rst, .master_clear_n, .sleeping, .wdt_timeout,
    .clear_watchdog_instr, .reg_rd, .reg_rdata, .core_reset, .pc_load, .int_vector_req, .timeout_flag,
    .powerdown_flag, .global_int_disable, .stack_available_flag, .pc_value);
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int PWR = 50;
    localparam int OSTN = 8;
    logic sys_clk = 1'b0, rst = 1'b1, pinLow = 1'b1, sleeping = 1'b0, wdt_timeout = 1'b0, wake_irq = 1'b0;
    logic clear_watchdog_instr = 1'b0, global_int_disable_in = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [1:0] osc_mode = 2'h1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [15:0] pc_current = 16'h0000;
    wire logic master_clear_n, osc_pulse, osc_valid, core_reset, pc_load, int_vector_req, irq;
    wire logic timeout_flag, powerdown_flag, global_int_disable, stack_available_flag;
    wire logic [7:0] reg_rdata;
    wire logic [15:0] pc_value;
    int errors = 0, samples_checked = 0, tn = 0;
    rtsl_osc_model u_rtsl_osc_model (.sys_clk, .pinLow, .master_clear_n, .osc_pulse, .osc_valid);
    rtsl_sequencer #(.PWRUP_CYCLES(PWR), .OSC_WAIT_COUNT(OSTN)) u_rtsl_sequencer (.sys_clk, .rst, .master_clear_n,
        .osc_pulse, .osc_valid, .osc_mode, .sleeping, .wdt_timeout, .wake_irq, .clear_watchdog_instr,
        .pc_current, .global_int_disable_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_reset,
        .pc_load, .pc_value, .int_vector_req, .timeout_flag, .powerdown_flag, .global_int_disable,
        .stack_available_flag, .irq);
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdReg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask
    // Fire one event, count cycles to release, then check what the core is handed
    task automatic rel(input logic [2:0] ev, input logic [15:0] pcExp, input logic [3:0] flExp, input int lo, hi);
        int n;
        logic vec;
        n = 0;
        vec = 1'b0;
        @(posedge sys_clk);
        {clear_watchdog_instr, wake_irq, wdt_timeout} <= ev;
        pinLow <= 1'b0;
        do begin
            @(posedge sys_clk);
            {clear_watchdog_instr, wake_irq, wdt_timeout} <= 3'h0;
            #1;
            n++;
            vec = vec | int_vector_req;
        end while (pc_load !== 1'b1 && n < 3000);
        chk({15'h0, n >= lo && n <= hi}, 16'h0001);
        chk(pc_value, pcExp);
        chk({12'h0, stack_available_flag, global_int_disable, timeout_flag, powerdown_flag}, {12'h0, flExp});
        chk({15'h0, vec}, {15'h0, !global_int_disable_in && ev[1]});
        chk({15'h0, core_reset}, 16'h0000);
        $display("test %0d done", ++tn);
    endtask
    ////////////////////////////////////////
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        #(50 * 5000);
        errors++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (5) @(posedge sys_clk);
        rel(3'h0, 16'h0000, 4'hF, PWR - 1, PWR + 20);
        rel(3'h1, 16'h0000, 4'hD, 1, 6);
        @(posedge sys_clk);
        clear_watchdog_instr <= 1'b1;
        @(posedge sys_clk);
        clear_watchdog_instr <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 chk({14'h0, timeout_flag, powerdown_flag}, 16'h0003);
        sleeping <= 1'b1;
        rel(3'h1, 16'h0000, 4'hC, 2 * OSTN - 2, 2 * OSTN + 20);
        pinLow <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rel(3'h0, 16'h0000, 4'hE, 2 * OSTN - 2, 2 * OSTN + 20);
        pc_current <= 16'h7FFF;
        for (int g = 0; g < 2; g++) begin
            global_int_disable_in <= g[0];
            osc_mode <= g[0] ? 2'h0 : 2'h1;
            rel(3'h2, 16'h8000, {1'b1, g[0], 2'b10}, 2 * OSTN - 2, 2 * OSTN + 20);
        end
        osc_mode <= 2'h3;
        rel(3'h2, 16'h8000, 4'hE, 1, 6);
        sleeping <= 1'b0;
        osc_mode <= 2'h2;
        pinLow <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rel(3'h0, 16'h0000, 4'hF, 1, 6);
        wrReg(4'h1, 8'h08);
        repeat (2) @(posedge sys_clk);
        #1 chk({15'h0, irq}, 16'h0001);
        rdReg(4'h0, 8'h0F);
        wrReg(4'h0, 8'hFF);
        wrReg(4'hF, 8'hFF);
        repeat (2) @(posedge sys_clk);
        #1 chk({15'h0, irq}, 16'h0000);
        rdReg(4'h0, 8'h00);
        rdReg(4'h1, 8'h08);
        rdReg(4'hF, 8'h00);
        rdReg(4'h2, 8'h02);
        rdReg(4'h3, 8'h3E);
        $display("test %0d done", ++tn);
        close_out();
    end
endmodule
`default_nettype wire
